// File: logic/sai_pkg.sv
// Constants, register map and types of the serial auto-transfer interval
// control. Assumes a 32-bit AHB-Lite bus and a main clock derived from hclk.
// Overview of operation
// [R01] Enable clear: gap left to processor handling.
// [R02] Enable set: gap from 5-bit count.
// [R03] Least gap (n+1)*64+28 clocks plus half sck.
// [R04] Longest gap (n+1)*64+36 clocks plus 1.5 sck.
// [R05] Gap never below two serial-clock periods.
// [R06] Software leaves interval register alone while active.
// [R07] Software writes zeros to bits 5 and 6.
// [R08] Timed gaps ignore the busy handshake input.
// [R09] Time base is main clock, full or half.
// [R10] Modes: stopped, plain 3-wire, auto 3-wire.
// [R11] Active flag bit 3 while auto transfer runs.
// [R12] Mode bit selects auto or plain 3-wire.
// [R13] Each byte restarts gap; next byte waits.
package sai_pkg;
  localparam int          HCLK_MHZ      = 250;
  localparam int          HCLK_NS       = 1000 / HCLK_MHZ;
  // Register indices; the byte address is four times the index.
  localparam logic [15:0] IDX_INTERVAL  = 16'hFF6B;
  localparam logic [15:0] IDX_MODE      = 16'hFF68;
  localparam logic [15:0] IDX_CONTROL   = 16'hFF6A;
  localparam logic [7:0]  RST_INTERVAL  = 8'h00;
  localparam logic [7:0]  RST_MODE      = 8'h00;
  localparam logic [7:0]  RST_CONTROL   = 8'h00;
  localparam int          BIT_IV_EN     = 7;
  localparam int          BIT_CNT_LO    = 0;
  localparam int          BIT_CNT_HI    = 4;
  localparam logic [7:0]  IV_MASK       = 8'h9F;
  localparam int          BIT_SER_EN    = 7;
  localparam int          BIT_DIR       = 6;
  localparam int          BIT_AUTO_SEL  = 5;
  localparam logic [7:0]  MODE_MASK     = 8'hE3;
  localparam int          BIT_ACTIVE    = 3;
  localparam int          BIT_HALF_CLK  = 0;
  localparam logic [7:0]  CTRL_MASK     = 8'h09;
  // Interval timing in main-clock periods and serial-clock periods.
  localparam int          STEP_SHIFT    = 6;
  localparam logic [11:0] MIN_OVERHEAD  = 12'd28;
  localparam logic [11:0] MAX_OVERHEAD  = 12'd36;
  localparam logic [1:0]  MIN_SCK_PER   = 2'd2;
  localparam int          CNT_W         = 12;
  typedef enum logic [1:0] {SAI_STOP, SAI_PLAIN, SAI_AUTO} sai_mode_t;
  typedef enum logic [1:0] {GAP_IDLE, GAP_COUNT, GAP_SCK} sai_gap_st_t;
endpackage : sai_pkg

// File: logic/sai_gap_if.sv
// Carrier between the top and the gap timer.
// Assumes both ends run on hclk.
`timescale 1ns/1ps
`default_nettype none
interface sai_gap_if;
  logic       start;
  logic [4:0] count;
  logic       fxx_tick;
  logic       sck_tick;
  logic       done;
  logic       busy;
  modport ctrl  (output start, count, fxx_tick, sck_tick,
                 input done, busy);
  modport timer (input start, count, fxx_tick, sck_tick,
                 output done, busy);
endinterface : sai_gap_if
`default_nettype wire

// File: logic/sai_tick_gen.sv
// Main-clock tick generator: one pulse per main-clock period, or one per two periods when half_clk is set.
// Assumes hclk is the oscillator clock.
`timescale 1ns/1ps
`default_nettype none
module sai_tick_gen (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic half_clk,
  output var  logic tick
);
  import sai_pkg::*;
  logic phase_ff;
  logic nxt_phase;
  logic tick_ff;
  logic nxt_tick;

  always_comb begin
    nxt_phase = half_clk ? ~phase_ff : 1'b0;
    nxt_tick  = ~half_clk | phase_ff; // see [R09]
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_ff <= 1'b0;
      tick_ff  <= 1'b0;
    end else begin
      phase_ff <= nxt_phase;
      tick_ff  <= nxt_tick;
    end
  end

  assign tick = tick_ff;
endmodule : sai_tick_gen
`default_nettype wire

// File: logic/sai_gap_timer.sv
// Inter-byte gap timer of the automatic transfer.
// Assumes start arrives only when interval timing is enabled.
`timescale 1ns/1ps
`default_nettype none
module sai_gap_timer (
  input  wire logic hclk,
  input  wire logic hresetn,
  sai_gap_if.timer  gap
);
  import sai_pkg::*;
  sai_gap_st_t      st_ff;
  sai_gap_st_t      nxt_st;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic [1:0]       sck_ff;
  logic [1:0]       nxt_sck;
  logic             done_ff;
  logic             nxt_done;

  always_comb begin
    nxt_st   = st_ff;
    nxt_cnt  = cnt_ff;
    nxt_sck  = sck_ff;
    nxt_done = 1'b0;
    if (gap.sck_tick && sck_ff != MIN_SCK_PER) begin
      nxt_sck = sck_ff + 2'd1;
    end
    unique case (st_ff)
      GAP_IDLE: begin
        if (gap.start) begin
          // Load (n+1)*64 + 28 main-clock periods.
          nxt_cnt = CNT_W'((CNT_W'(gap.count) + 12'd1) << STEP_SHIFT)
                    + MIN_OVERHEAD - 12'd1; // see [R03]
          nxt_sck = 2'd0;
          nxt_st  = GAP_COUNT; // see [R13]
        end
      end
      GAP_COUNT: begin
        if (gap.fxx_tick) begin
          if (cnt_ff == '0) begin
            nxt_st = GAP_SCK;
          end else begin
            nxt_cnt = cnt_ff - 12'd1;
          end
        end
      end
      GAP_SCK: begin
        // End on a serial-clock edge, no earlier than the second sck tick since the start.
        if (gap.sck_tick && sck_ff >= MIN_SCK_PER - 2'd1) begin // see [R05]
          nxt_done = 1'b1; // see [R04]
          nxt_st   = GAP_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff   <= GAP_IDLE;
      cnt_ff  <= '0;
      sck_ff  <= 2'd0;
      done_ff <= 1'b0;
    end else begin
      st_ff   <= nxt_st;
      cnt_ff  <= nxt_cnt;
      sck_ff  <= nxt_sck;
      done_ff <= nxt_done;
    end
  end

  assign gap.done = done_ff;
  assign gap.busy = (st_ff != GAP_IDLE);
endmodule : sai_gap_timer
`default_nettype wire

// File: logic/sai_top.sv
// Top of the serial auto-transfer interval control with its AHB-Lite
// register slave. Assumes the shift engine and sequencer run on hclk and
// that the busy pin is asynchronous.
`timescale 1ns/1ps
`default_nettype none
module sai_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  input  wire logic        sck_tick,
  input  wire logic        byte_done,
  input  wire logic        auto_start,
  input  wire logic        auto_end,
  input  wire logic        cpu_next,
  input  wire logic        busy_pin,
  output var  logic [1:0]  op_mode,
  output var  logic        lsb_first,
  output var  logic        auto_transfer_active,
  output var  logic        next_byte_go,
  output var  logic        busy_ignored,
  output var  logic        gap_pending
);
  import sai_pkg::*;

  sai_gap_if gap ();
  logic      fxx_tick;

  // Address phase capture.
  logic        wr_ff;
  logic        nxt_wr;
  logic        rd_ff;
  logic        nxt_rd;
  logic [15:0] idx_ff;
  logic [15:0] nxt_idx;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic        ready_ff;
  logic        resp_ff;
  logic        take;
  logic        hit;
  logic [15:0] a_idx;

  // Registers.
  logic [7:0]  iv_ff;
  logic [7:0]  nxt_iv;
  logic [7:0]  mode_ff;
  logic [7:0]  nxt_mode;
  logic        half_ff;
  logic        nxt_half;
  logic        act_ff;
  logic        nxt_act;

  // Busy pin synchroniser.
  logic        busy_s1_ff;
  logic        busy_s2_ff;

  // Outputs toward the serial channel.
  sai_mode_t   mode_ff2;
  sai_mode_t   nxt_op;
  logic        lsb_ff;
  logic        go_ff;
  logic        nxt_go;
  logic        bign_ff;
  logic        nxt_bign;
  logic        pend_ff;
  logic        nxt_pend;
  logic        timed;

  assign take  = hsel & htrans[1] & hready;
  assign a_idx = haddr[17:2];
  assign hit   = (haddr[31:18] == 14'h0000) && (haddr[1:0] == 2'b00);

  // Bus slave: reads answer with data latched at the address phase.
  always_comb begin
    nxt_wr    = take & hwrite;
    nxt_rd    = take & ~hwrite;
    nxt_idx   = take ? a_idx : idx_ff;
    nxt_rdata = 32'h0000_0000;
    if (take && !hwrite && hit) begin
      unique case (a_idx)
        IDX_INTERVAL: nxt_rdata = {24'h00_0000, iv_ff};
        IDX_MODE:     nxt_rdata = {24'h00_0000, mode_ff};
        IDX_CONTROL:  nxt_rdata = {24'h00_0000, 4'h0, act_ff,
                                   2'b00, half_ff}; // see [R11]
        default:      nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ff    <= 1'b0;
      rd_ff    <= 1'b0;
      idx_ff   <= 16'h0000;
      rdata_ff <= 32'h0000_0000;
      ready_ff <= 1'b0;
      resp_ff  <= 1'b0;
    end else begin
      wr_ff    <= nxt_wr & hit;
      rd_ff    <= nxt_rd;
      idx_ff   <= nxt_idx;
      rdata_ff <= nxt_rdata;
      ready_ff <= 1'b1;
      resp_ff  <= 1'b0;
    end
  end

  // Register writes land in the data phase.
  always_comb begin
    nxt_iv   = iv_ff;
    nxt_mode = mode_ff;
    nxt_half = half_ff;
    if (wr_ff) begin
      unique case (idx_ff)
        // Bits 5 and 6 are held at zero whatever is written.
        IDX_INTERVAL: nxt_iv   = hwdata[7:0] & IV_MASK; // see [R07]
        IDX_MODE:     nxt_mode = hwdata[7:0] & MODE_MASK;
        IDX_CONTROL:  nxt_half = hwdata[BIT_HALF_CLK];
        default:      nxt_iv   = iv_ff;
      endcase
    end
  end

  // Active flag: a start in auto mode in the same cycle as an end keeps it set.
  always_comb begin
    nxt_act = act_ff;
    if (auto_end) begin
      nxt_act = 1'b0;
    end
    if (auto_start && mode_ff2 == SAI_AUTO) begin
      nxt_act = 1'b1; // see [R11]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      iv_ff   <= RST_INTERVAL;
      mode_ff <= RST_MODE;
      half_ff <= RST_CONTROL[BIT_HALF_CLK];
      act_ff  <= RST_CONTROL[BIT_ACTIVE];
    end else begin
      iv_ff   <= nxt_iv;
      mode_ff <= nxt_mode;
      half_ff <= nxt_half;
      act_ff  <= nxt_act;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_s1_ff <= 1'b0;
      busy_s2_ff <= 1'b0;
    end else begin
      busy_s1_ff <= busy_pin;
      busy_s2_ff <= busy_s1_ff;
    end
  end

  sai_tick_gen u_tick (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .half_clk (half_ff),
    .tick     (fxx_tick)
  );

  sai_gap_timer u_gap (
    .hclk    (hclk),
    .hresetn (hresetn),
    .gap     (gap.timer)
  );

  assign timed        = iv_ff[BIT_IV_EN] & (mode_ff2 == SAI_AUTO);
  assign gap.start    = byte_done & act_ff & timed; // see [R02]
  assign gap.count    = iv_ff[BIT_CNT_HI:BIT_CNT_LO];
  assign gap.fxx_tick = fxx_tick; // see [R09]
  assign gap.sck_tick = sck_tick;

  // Mode, permission for the next byte and busy gating.
  always_comb begin
    if (!mode_ff[BIT_SER_EN]) begin
      nxt_op = SAI_STOP; // see [R10]
    end else if (mode_ff[BIT_AUTO_SEL]) begin
      nxt_op = SAI_AUTO; // see [R12]
    end else begin
      nxt_op = SAI_PLAIN; // see [R12]
    end
    nxt_bign = timed; // see [R08]
    nxt_pend = gap.busy;
    nxt_go   = 1'b0;
    if (mode_ff2 != SAI_STOP) begin
      if (timed) begin
        // The handshake input has no say while the gap is timed.
        nxt_go = gap.done; // see [R13]
      end else begin
        // Untimed: the next byte follows the processor's request.
        nxt_go = cpu_next & ~busy_s2_ff; // see [R01]
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_ff2 <= SAI_STOP;
      lsb_ff   <= 1'b0;
      go_ff    <= 1'b0;
      bign_ff  <= 1'b0;
      pend_ff  <= 1'b0;
    end else begin
      mode_ff2 <= nxt_op;
      lsb_ff   <= mode_ff[BIT_DIR];
      go_ff    <= nxt_go;
      bign_ff  <= nxt_bign;
      pend_ff  <= nxt_pend;
    end
  end

  assign hrdata               = rdata_ff;
  assign hreadyout            = ready_ff;
  assign hresp                = resp_ff;
  assign op_mode              = mode_ff2;
  assign lsb_first            = lsb_ff;
  assign auto_transfer_active = act_ff;
  assign next_byte_go         = go_ff;
  assign busy_ignored         = bign_ff;
  assign gap_pending          = pend_ff;
endmodule : sai_top
`default_nettype wire

// File: testbench/sai_chk.sv
// Checker of the interval control, watching the top ports only.
// Assumes zero-wait bus writes; bound into sai_top at the foot.
`timescale 1ns/1ps
`default_nettype none
module sai_chk (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        sck_tick,
  input wire logic        byte_done,
  input wire logic        auto_start,
  input wire logic        auto_end,
  input wire logic        cpu_next,
  input wire logic        busy_pin,
  input wire logic [1:0]  op_mode,
  input wire logic        auto_transfer_active,
  input wire logic        next_byte_go,
  input wire logic        busy_ignored,
  input wire logic        gap_pending
);
  import sai_pkg::*;
  logic        wp_ff;
  logic [31:0] wa_ff;
  logic [7:0]  iv_ff;
  logic [7:0]  md_ff;
  logic [11:0] cnt_ff;
  logic [2:0]  sk_ff;
  logic        timed;
  assign timed = iv_ff[BIT_IV_EN] && op_mode == 2'd2;
  // Shadows of two registers, and cycles and sck ticks since a timed byte.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp_ff  <= 1'b0;
      wa_ff  <= 32'h0;
      iv_ff  <= 8'h00;
      md_ff  <= 8'h00;
      cnt_ff <= 12'h000;
      sk_ff  <= 3'h0;
    end else begin
      wp_ff <= hsel && htrans[1] && hready && hwrite;
      wa_ff <= haddr;
      if (wp_ff && wa_ff == 32'(IDX_INTERVAL) << 2) begin
        iv_ff <= hwdata[7:0] & IV_MASK;
      end
      if (wp_ff && wa_ff == 32'(IDX_MODE) << 2) begin
        md_ff <= hwdata[7:0];
      end
      if (byte_done && timed) begin
        cnt_ff <= 12'h000;
        sk_ff  <= 3'h0;
      end else begin
        cnt_ff <= cnt_ff + {11'h0, cnt_ff != 12'hFFF};
        sk_ff  <= sk_ff + {2'h0, sck_tick && sk_ff != 3'h7};
      end
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_gap_floor: assert property (next_byte_go && timed |->
    32'(cnt_ff) >= (32'(iv_ff[4:0]) + 1) * 64 + 28) else $error("gap short");
  a_gap_two_sck: assert property (next_byte_go && timed |->
    sk_ff >= 3'd2) else $error("gap under two sck");
  a_go_single: assert property (next_byte_go |=>
    !next_byte_go) else $error("go too long");
  a_gap_timed: assert property ($rose(gap_pending) |->
    iv_ff[BIT_IV_EN] && op_mode == 2'd2) else $error("untimed gap");
  a_busy_off: assert property (gap_pending |->
    busy_ignored) else $error("busy not ignored");
  a_cpu_go: assert property ((!busy_pin)[*3] ##0
    (cpu_next && !timed && op_mode != 2'd0) |=> next_byte_go)
    else $error("cpu go missing");
  a_busy_hold: assert property (busy_pin[*3] ##0
    (cpu_next && !timed) |=> !next_byte_go) else $error("busy ignored");
  a_act_set: assert property (auto_start && op_mode == 2'd2 |=>
    auto_transfer_active) else $error("active not set");
  a_act_clear: assert property (auto_end && !auto_start |=>
    !auto_transfer_active) else $error("active not cleared");
  a_mode_map: assert property (op_mode == (!$past(md_ff[7]) ?
    2'd0 : $past(md_ff[5]) ? 2'd2 : 2'd1)) else $error("mode wrong");
  c_timed_go: cover property (next_byte_go && timed);
  c_cpu_go: cover property (cpu_next && !timed ##1 next_byte_go);
  c_active: cover property ($rose(auto_transfer_active));
endmodule : sai_chk
bind sai_top sai_chk u_chk (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .sck_tick, .byte_done, .auto_start, .auto_end, .cpu_next, .busy_pin,
  .op_mode, .auto_transfer_active, .next_byte_go, .busy_ignored,
  .gap_pending
);
`default_nettype wire

// File: testbench/sai_peer.sv
// Serial peer: makes sck ticks only while a transfer runs, shifts bytes.
// Assumes a byte starts on kick or on the block's go pulse.
`timescale 1ns/1ps
`default_nettype none
module sai_peer (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       run,
  input  wire logic [7:0] sck_per,
  input  wire logic       kick,
  input  wire logic       go,
  output var  logic       sck_tick,
  output var  logic       byte_done
);
  logic [7:0] div_ff;
  logic [3:0] bit_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_ff    <= 8'h00;
      bit_ff    <= 4'h0;
      sck_tick  <= 1'b0;
      byte_done <= 1'b0;
    end else begin
      sck_tick  <= run && div_ff == 8'h00;
      div_ff    <= (!run || div_ff == sck_per - 8'h01) ? 8'h00 : div_ff + 8'h01;
      byte_done <= sck_tick && bit_ff == 4'h1 && !(kick || go);
      if (kick || go) begin
        bit_ff <= 4'h8;
      end else if (sck_tick && bit_ff != 4'h0) begin
        bit_ff <= bit_ff - 4'h1;
      end
    end
  end
endmodule : sai_peer
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench of the interval control over AHB-Lite.
// Assumes the peer model stands on the serial side.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sai_pkg::*;
  localparam logic [31:0] A_IV = 32'(IDX_INTERVAL) << 2;
  localparam logic [31:0] A_MD = 32'(IDX_MODE) << 2;
  localparam logic [31:0] A_CT = 32'(IDX_CONTROL) << 2;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic [1:0]  op_mode;
  logic        sck_tick, byte_done, next_byte_go, auto_transfer_active;
  logic        auto_start = 1'b0, auto_end = 1'b0, kick = 1'b0;
  logic        cpu_next = 1'b0, busy_pin = 1'b0;
  logic [7:0]  sck_per = 8'h08;
  int          errors = 0, tests_run = 0, cyc = 0;
  int          gap_c = 0, gap_last = 0, go_n = 0;
  always #2 hclk = ~hclk;
  sai_top u_dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp(),
    .sck_tick, .byte_done, .auto_start, .auto_end, .cpu_next, .busy_pin,
    .op_mode, .lsb_first(), .auto_transfer_active, .next_byte_go,
    .busy_ignored(), .gap_pending()
  );
  sai_peer u_peer (
    .hclk, .hresetn, .run(auto_transfer_active), .sck_per, .kick,
    .go(next_byte_go), .sck_tick, .byte_done
  );
  always @(posedge hclk) begin
    gap_c <= byte_done ? 0 : gap_c + 1;
    if (next_byte_go === 1'b1) begin
      gap_last <= gap_c + 1;
      go_n     <= go_n + 1;
    end
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask : rd
  // Pulses one of the sequencer strobes: 0 start, 1 end, 2 kick, 3 cpu.
  task automatic pulse(input int k);
    @(posedge hclk);
    {auto_start, auto_end, kick, cpu_next} <= 4'b1000 >> k;
    @(posedge hclk);
    {auto_start, auto_end, kick, cpu_next} <= 4'b0000;
  endtask : pulse
  task automatic gap(input int n, input int h, input int per);
    int lo;
    int hi;
    int base;
    lo = ((n + 1) * 64 + 28) * (h + 1);
    lo = (lo < 2 * per) ? 2 * per : lo;
    hi = ((n + 1) * 64 + 36) * (h + 1) + 2 * per + 4;
    sck_per <= 8'(per);
    wr(A_CT, 32'(h));
    wr(A_IV, 32'(128 + n));
    wr(A_MD, 32'hA0);
    busy_pin <= 1'b1;
    pulse(0);
    rd(A_CT, 32'(8 + h));
    base = go_n;
    pulse(2);
    while (go_n == base) @(posedge hclk);
    @(posedge hclk);
    chk(32'(gap_last >= lo && gap_last <= hi), 32'h1);
    pulse(1);
    busy_pin <= 1'b0;
    rd(A_CT, 32'(h));
  endtask : gap
  initial begin
    int base;
    logic [7:0] mds [3];
    mds = '{8'h80, 8'hA0, 8'h00};
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd(A_IV, 32'h0);
    rd(A_MD, 32'h0);
    rd(A_CT, 32'h0);
    wr(A_IV, 32'hFF);
    rd(A_IV, 32'h9F);
    wr(A_CT, 32'hFF);
    rd(A_CT, 32'h01);
    wr(32'h0, 32'hFF);
    rd(32'h0, 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(A_MD, 32'(mds[i]));
      repeat (2) @(posedge hclk);
      chk(32'(op_mode), 32'((i + 1) % 3));
    end
    gap(0, 0, 8);
    gap(1, 0, 8);
    gap(31, 0, 8);
    gap(0, 1, 8);
    gap(0, 0, 60);
    wr(A_IV, 32'h0);
    pulse(0);
    base = go_n;
    pulse(2);
    repeat (300) @(posedge hclk);
    chk(32'(go_n - base), 32'h0);
    busy_pin <= 1'b1;
    repeat (3) @(posedge hclk);
    pulse(3);
    repeat (3) @(posedge hclk);
    chk(32'(go_n - base), 32'h0);
    busy_pin <= 1'b0;
    repeat (3) @(posedge hclk);
    pulse(3);
    repeat (3) @(posedge hclk);
    chk(32'(go_n - base), 32'h1);
    pulse(1);
    stop_test();
  end
endmodule : testbench
`default_nettype wire
